// ===== dv/cfr_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfr_map.svh"

module cfr_top_test
  import cfr_pkg::*;
;
  localparam logic [6:0] ADDR    = 7'h2a; // Arbitrary value
  localparam int         CPS     = 20;
  localparam int         MAX_CYC = 60000;

  logic           clk;
  logic           rst;
  logic           scl;
  logic           sda_drv;
  logic           supply_ok;
  logic           below;
  logic           peak;
  logic           warn;
  logic           shut;
  cfr_temp_t      temp;
  logic           sda_out;
  logic           sda_oe;
  cfr_short_cfg_t short_cfg;
  logic [11:0]    short_thr_mv;
  cfr_therm_cfg_t therm_cfg;
  logic [12:0]    beta_value;
  logic           device_shutdown;
  logic           charge_stop;
  cfr_scale_t     cur_scale;
  wire logic      sda_w;
  int             fails;
  int             tests_run;
  int             cycles;

  logic [12:0] beta_tab [16] = '{13'h092e, 13'h0a28, 13'h0abe, 13'h0bb8, 13'h0c4e, 13'h0d16,
                                 13'h0dac, 13'h0e10, 13'h0ed8, 13'h0fa0, 13'h1068, 13'h1130,
                                 13'h11f8, 13'h12c0, 13'h1388, 13'h1450};
  logic [7:0]  creg [7] = '{8'h27, 8'h27, 8'ha7, 8'h27, 8'h67, 8'h27, 8'h07};
  logic [3:0]  ctmp [7] = '{4'h0, 4'h4, 4'h4, 4'hc, 4'h4, 4'h2, 4'h2};
  logic [2:0]  cexp [7] = '{3'h3, 3'h2, 3'h1, 3'h4, 3'h4, 3'h3, 3'h4};

  // Open-drain line with pull-up: low if either side pulls
  assign sda_w = sda_drv & ~sda_oe;

  cfr_top #(
    .DEV_ADDR    (ADDR),
    .RNTC_FACTORY(1'b0),
    .BETA_FACTORY(4'h7),
    .CYC_PER_SEC (CPS)
  ) u_dut (
    .clk                (clk),
    .rst                (rst),
    .scl                (scl),
    .sda_in             (sda_w),
    .sda_out            (sda_out),
    .sda_oe             (sda_oe),
    .input_bus_supply_ok(supply_ok),
    .battery_below_short(below),
    .inductor_peak_fault(peak),
    .overtemp_warning   (warn),
    .overtemp_shutdown  (shut),
    .temp               (temp),
    .short_cfg          (short_cfg),
    .short_thr_mv       (short_thr_mv),
    .therm_cfg          (therm_cfg),
    .beta_value         (beta_value),
    .device_shutdown    (device_shutdown),
    .charge_stop        (charge_stop),
    .cur_scale          (cur_scale)
  );

  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (fails == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  always @(posedge clk) begin
    cycles++;
    if (cycles == MAX_CYC) begin
      fails++;
      finish_test();
    end
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_clk

  ////////////////////////////////////////////////////////////////////////////////
  // Serial port: five clocks per phase keeps well above the synchroniser delay
  task automatic i2c_bit(input logic b, output logic r);
    sda_drv = b;
    wait_clk(5);
    scl = 1'b1;
    wait_clk(5);
    r = sda_w;
    wait_clk(5);
    scl = 1'b0;
    wait_clk(5);
  endtask : i2c_bit

  task automatic i2c_start();
    sda_drv = 1'b1;
    wait_clk(5);
    scl = 1'b1;
    wait_clk(10);
    sda_drv = 1'b0;
    wait_clk(10);
    scl = 1'b0;
    wait_clk(5);
  endtask : i2c_start

  task automatic i2c_stop();
    sda_drv = 1'b0;
    wait_clk(5);
    scl = 1'b1;
    wait_clk(10);
    sda_drv = 1'b1;
    wait_clk(10);
  endtask : i2c_stop

  task automatic i2c_byte(input logic [7:0] d, input logic m_ack, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(d[i], r[i]);
    end
    i2c_bit(m_ack, a);
  endtask : i2c_byte

  task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] d);
    logic [7:0] r;
    i2c_start();
    i2c_byte({ADDR, 1'b0}, 1'b1, r);
    i2c_byte(ptr, 1'b1, r);
    i2c_byte(d, 1'b1, r);
    i2c_stop();
    wait_clk(3);
  endtask : wr_reg

  // Master sends all ones while reading so the target alone shapes the line
  task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp);
    logic [7:0] r;
    i2c_start();
    i2c_byte({ADDR, 1'b0}, 1'b1, r);
    i2c_byte(ptr, 1'b1, r);
    i2c_start();
    i2c_byte({ADDR, 1'b1}, 1'b1, r);
    i2c_byte(8'hff, 1'b1, r);
    i2c_stop();
    chk($sformatf("reg %h", ptr), {8'h00, r}, {8'h00, exp});
    chk("sda_out", 16'(sda_out), 16'h0000);
  endtask : rd_chk

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    chk("short_cfg", 16'(short_cfg), 16'h0024);
    chk("short_thr_mv", 16'(short_thr_mv), 16'h0960);
    chk("therm_cfg", 16'(therm_cfg), 16'h0027);
    chk("beta_value", 16'(beta_value), 16'h0e10);
    rd_chk(`CFR_REG_FAULT, 8'h00);
    rd_chk(`CFR_REG_SHORT, 8'h84);
    rd_chk(`CFR_REG_THERM, 8'h27);
  endtask : test_reset

  task automatic test_config();
    for (int k = 0; k < 8; k++) begin
      wr_reg(`CFR_REG_SHORT, {k[2:0], 2'b11, k[2:0]});
      chk("short_cfg", 16'(short_cfg), 16'({k[2:0], k[2:0]}));
      chk("short_thr_mv", 16'(short_thr_mv), 16'(12'h7d0 + 12'(k) * 12'h064));
    end
    wr_reg(8'h20, 8'hff);
    rd_chk(8'h20, 8'h00);
    rd_chk(`CFR_REG_SHORT, 8'he7);
    for (int k = 0; k < 16; k++) begin
      wr_reg(`CFR_REG_THERM, {4'h3, k[3:0]});
      chk("therm_cfg", 16'(therm_cfg), 16'({4'h3, k[3:0]}));
      chk("beta_value", 16'(beta_value), 16'(beta_tab[k]));
    end
    rd_chk(`CFR_REG_THERM, 8'h3f);
  endtask : test_config

  task automatic test_charge();
    for (int i = 0; i < 7; i++) begin
      // Application-style writes keep the factory beta code as it is
      wr_reg(`CFR_REG_THERM, creg[i]);
      temp = cfr_temp_t'(ctmp[i]);
      wait_clk(5);
      chk("charge", 16'({charge_stop, cur_scale}), 16'(cexp[i]));
      chk("beta_value", 16'(beta_value), 16'h0e10);
    end
    temp = '0;
  endtask : test_charge

  // One second is 20 cycles here, so code 1 needs 40 continuous cycles
  task automatic test_short();
    wr_reg(`CFR_REG_SHORT, 8'h24);
    chk("short_cfg", 16'(short_cfg), 16'h000c);
    below = 1'b1;
    wait_clk(35);
    below = 1'b0;
    rd_chk(`CFR_REG_FAULT, 8'h00);
    below = 1'b1;
    wait_clk(48);
    below = 1'b0;
    rd_chk(`CFR_REG_FAULT, 8'h08);
  endtask : test_short

  task automatic test_flags();
    wr_reg(`CFR_REG_FAULT, 8'h08);
    rd_chk(`CFR_REG_FAULT, 8'h00);
    peak = 1'b1;
    warn = 1'b1;
    shut = 1'b1;
    wait_clk(3);
    peak = 1'b0;
    warn = 1'b0;
    shut = 1'b0;
    wait_clk(5);
    chk("device_shutdown", 16'(device_shutdown), 16'h0001);
    chk("charge_stop", 16'(charge_stop), 16'h0001);
    // Write without a fresh read must leave the flags alone
    wr_reg(`CFR_REG_FAULT, 8'h07);
    rd_chk(`CFR_REG_FAULT, 8'h07);
    wr_reg(`CFR_REG_FAULT, 8'h02);
    rd_chk(`CFR_REG_FAULT, 8'h05);
    wr_reg(`CFR_REG_FAULT, 8'h05);
    rd_chk(`CFR_REG_FAULT, 8'h00);
    chk("device_shutdown", 16'(device_shutdown), 16'h0000);
    peak = 1'b1;
    wait_clk(3);
    peak = 1'b0;
    rd_chk(`CFR_REG_FAULT, 8'h04);
    supply_ok = 1'b0;
    wait_clk(5);
    supply_ok = 1'b1;
    wait_clk(5);
    rd_chk(`CFR_REG_FAULT, 8'h00);
  endtask : test_flags

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk       = 1'b0;
    rst       = 1'b1;
    scl       = 1'b1;
    sda_drv   = 1'b1;
    supply_ok = 1'b1;
    below     = 1'b0;
    peak      = 1'b0;
    warn      = 1'b0;
    shut      = 1'b0;
    temp      = '0;
    fails     = 0;
    tests_run = 0;
    cycles    = 0;
    wait_clk(20);
    rst = 1'b0;
    wait_clk(5);
    test_reset();
    test_config();
    test_charge();
    test_short();
    test_flags();
    finish_test();
  end

endmodule : cfr_top_test

`default_nettype wire

// ===== inc/cfr_map.svh
`ifndef CFR_MAP_SVH
`define CFR_MAP_SVH

// Register offsets on the serial port
`define CFR_REG_FAULT     8'h0a
`define CFR_REG_SHORT     8'h0b
`define CFR_REG_THERM     8'h0c

// Fault flag positions
`define CFR_FLT_SHORT     3
`define CFR_FLT_PEAK      2
`define CFR_FLT_WARN      1
`define CFR_FLT_SHUT      0

// Reset values
`define CFR_SHORT_TMO_RST 3'h4
`define CFR_SHORT_VLT_RST 3'h4
`define CFR_THERM_HI_RST  3'h1

// Short threshold in millivolts: base plus step per code
`define CFR_VTHR_BASE_MV  12'd2000
`define CFR_VTHR_STEP_MV  12'd100

// Timing
`define CFR_CLK_HZ        100000000
`define CFR_TICK_S        1

`endif

// ===== inc/cfr_pkg.sv
package cfr_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ADDR = 4'b0001,
    ST_ACKA = 4'b0010,
    ST_PTR  = 4'b0011,
    ST_ACKP = 4'b0100,
    ST_WDAT = 4'b0101,
    ST_ACKW = 4'b0110,
    ST_RDAT = 4'b0111,
    ST_ACKR = 4'b1000
  } cfr_state_t;

  typedef enum logic [1:0] {
    CS_OFF   = 2'b00,
    CS_TENTH = 2'b01,
    CS_HALF  = 2'b10,
    CS_FULL  = 2'b11
  } cfr_scale_t;

  typedef struct packed {
    logic [2:0] timeout;
    logic [2:0] volt;
  } cfr_short_cfg_t;

  typedef struct packed {
    logic       cool_sel;
    logic       low_sel;
    logic       high_sel;
    logic       rntc;
    logic [3:0] beta;
  } cfr_therm_cfg_t;

  typedef struct packed {
    logic lt_0c;
    logic lt_10c;
    logic gt_45c;
    logic gt_60c;
  } cfr_temp_t;

endpackage : cfr_pkg

// ===== src/cfr_short_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfr_map.svh"

module cfr_short_timer #(
  parameter int CYC_PER_SEC = `CFR_CLK_HZ * `CFR_TICK_S
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       below,
  input  wire logic [2:0] sel,
  output var  logic       det_q
);

  logic [31:0] div_q;
  logic [7:0]  sec_q;

  if (CYC_PER_SEC < 2) begin : g_chk
    $error("cfr_short_timer: CYC_PER_SEC must be at least 2");
  end

  function automatic logic [7:0] secs(input logic [2:0] code);
    case (code)
      3'h0:    secs = 8'd1;
      3'h1:    secs = 8'd2;
      3'h2:    secs = 8'd4;
      3'h3:    secs = 8'd10;
      3'h4:    secs = 8'd30;
      3'h5:    secs = 8'd60;
      3'h6:    secs = 8'd120;
      default: secs = 8'd180;
    endcase
  endfunction : secs

  // Any bounce above the threshold restarts the whole wait
  always_ff @(posedge clk) begin
    if (rst || !below) begin
      div_q <= '0;
      sec_q <= '0;
    end else if (div_q == 32'(CYC_PER_SEC - 1)) begin
      div_q <= '0;
      if (sec_q != 8'hff) begin
        sec_q <= sec_q + 8'h1;
      end
    end else begin
      div_q <= div_q + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !below) begin
      det_q <= 1'b0;
    end else begin
      det_q <= (sec_q >= secs(sel));
    end
  end

  short_release_a: assert property (@(posedge clk) disable iff (rst)
    !below |=> !det_q && sec_q == 8'h0)
    else $error("short detect held after battery recovered");

  // Holds for whatever code the bench selects, so the scenario really reaches it
  short_timeout_a: assert property (@(posedge clk) disable iff (rst)
    below && sec_q == secs(sel) |=> det_q)
    else $error("short timeout not honoured");

endmodule : cfr_short_timer

`default_nettype wire

// ===== src/cfr_sync.sv
`timescale 1ns/1ps
`default_nettype none

module cfr_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output var  logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;

  if (WIDTH < 1) begin : g_chk
    $error("cfr_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule : cfr_sync

`default_nettype wire

// ===== src/cfr_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfr_map.svh"

// Operation
// - Battery short detection sets fault bit 3; reset value 0.
// - Inductor peak current-limit fault sets fault bit 2; reset value 0.
// - Overtemperature early warning sets fault bit 1; reset value 0.
// - Overtemperature sets fault bit 0 and shuts the device down; reset 0.
// - Flags stick until supply power cycles or host reads then writes one.
// - Short timeout bits 7:5 pick 1,2,4,10,30,60,120,180 s; default 30 s.
// - Short voltage bits 2:0 pick 2.0 to 2.7 V; default 2.4 V.
// - Cool range current is about 50% when bit 7 low, 10% when high.
// - Charging stops below 0 C or 10 C chosen by bit 6; default 0 C.
// - Charging stops above 45 C or 60 C chosen by bit 5; default 60 C.
// - Bit 4 picks 10 k or 100/47 k thermistor; factory default.
// - Bits 3:0 map to beta 2350 through 5200; factory default.
module cfr_top
  import cfr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR     = 7'h2a, // Arbitrary value
  parameter logic       RNTC_FACTORY = 1'b0,
  parameter logic [3:0] BETA_FACTORY = 4'h7,
  parameter int         CYC_PER_SEC  = `CFR_CLK_HZ * `CFR_TICK_S
) (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            scl,
  input  wire logic            sda_in,
  output var  logic            sda_out,
  output var  logic            sda_oe,
  input  wire logic            input_bus_supply_ok,
  input  wire logic            battery_below_short,
  input  wire logic            inductor_peak_fault,
  input  wire logic            overtemp_warning,
  input  wire logic            overtemp_shutdown,
  input  wire cfr_temp_t       temp,
  output var  cfr_short_cfg_t  short_cfg,
  output var  logic [11:0]     short_thr_mv,
  output var  cfr_therm_cfg_t  therm_cfg,
  output var  logic [12:0]     beta_value,
  output var  logic            device_shutdown,
  output var  logic            charge_stop,
  output var  cfr_scale_t      cur_scale
);

  ////////////////////////////////////////////////////////////////////////////
  logic [10:0]    pins_s;
  logic           scl_s, sda_s, vbus_s, below_s, ipk_s, warn_s, shut_s;
  cfr_temp_t      temp_s;
  logic           scl_d_q, sda_d_q;
  logic           scl_rise, scl_fall, start, stop;
  cfr_state_t     st_q;
  logic [3:0]     cnt_q;
  logic [7:0]     sh_q, out_q, ptr_q, rd_byte;
  logic           rw_q, nack_q, sda_oe_q, sda_out_q;
  logic           wr_en_q, rd_fault_q;
  logic [7:0]     wr_addr_q, wr_data_q;
  logic [3:0]     fault_q, armed_q, fault_set, fault_clr;
  cfr_short_cfg_t short_q;
  cfr_therm_cfg_t therm_q;
  logic           short_det, cool, stop_d;
  logic [11:0]    thr_mv_q;
  logic [12:0]    beta_q;
  logic           stop_q;
  cfr_scale_t     scale_q;

  if (CYC_PER_SEC < 2) begin : g_chk
    $error("cfr_top: CYC_PER_SEC must be at least 2");
  end

  cfr_sync #(
    .WIDTH (11)
  ) u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  ({scl, sda_in, input_bus_supply_ok, battery_below_short,
            inductor_peak_fault, overtemp_warning, overtemp_shutdown, temp}),
    .dout (pins_s)
  );

  assign {scl_s, sda_s, vbus_s, below_s, ipk_s, warn_s, shut_s} = pins_s[10:4];
  assign temp_s = pins_s[3:0];

  cfr_short_timer #(
    .CYC_PER_SEC (CYC_PER_SEC)
  ) u_short (
    .clk   (clk),
    .rst   (rst),
    .below (below_s),
    .sel   (short_q.timeout),
    .det_q (short_det)
  );

  function automatic logic [12:0] beta_of(input logic [3:0] code);
    case (code)
      4'h0:    beta_of = 13'd2350;
      4'h1:    beta_of = 13'd2600;
      4'h2:    beta_of = 13'd2750;
      4'h3:    beta_of = 13'd3000;
      4'h4:    beta_of = 13'd3150;
      4'h5:    beta_of = 13'd3350;
      4'h6:    beta_of = 13'd3500;
      4'h7:    beta_of = 13'd3600;
      4'h8:    beta_of = 13'd3800;
      4'h9:    beta_of = 13'd4000;
      4'ha:    beta_of = 13'd4200;
      4'hb:    beta_of = 13'd4400;
      4'hc:    beta_of = 13'd4600;
      4'hd:    beta_of = 13'd4800;
      4'he:    beta_of = 13'd5000;
      default: beta_of = 13'd5200;
    endcase
  endfunction : beta_of

  ////////////////////////////////////////////////////////////////////////////
  // Serial port: start/stop and clock edges on synchronised pins
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      scl_d_q <= scl_s;
      sda_d_q <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d_q;
  assign scl_fall = ~scl_s & scl_d_q;
  assign start    = scl_s & scl_d_q & sda_d_q & ~sda_s;
  assign stop     = scl_s & scl_d_q & ~sda_d_q & sda_s;

  always_comb begin
    case (ptr_q)
      `CFR_REG_FAULT: rd_byte = {4'h0, fault_q};
      `CFR_REG_SHORT: rd_byte = {short_q.timeout, 2'b00, short_q.volt};
      `CFR_REG_THERM: rd_byte = therm_q;
      default:        rd_byte = 8'h00;
    endcase
  end

  // Pointer auto-increments after each written data byte and as each read data byte is loaded
  always_ff @(posedge clk) begin
    wr_en_q    <= 1'b0;
    rd_fault_q <= 1'b0;
    if (rst) begin
      st_q      <= ST_IDLE;
      cnt_q     <= '0;
      sh_q      <= '0;
      out_q     <= '0;
      ptr_q     <= '0;
      rw_q      <= 1'b0;
      nack_q    <= 1'b1;
      sda_oe_q  <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= '0;
    end else if (start) begin
      st_q     <= ST_ADDR;
      cnt_q    <= '0;
      sda_oe_q <= 1'b0;
    end else if (stop) begin
      st_q     <= ST_IDLE;
      sda_oe_q <= 1'b0;
    end else if (scl_rise) begin
      if (st_q == ST_ADDR || st_q == ST_PTR || st_q == ST_WDAT) begin
        sh_q  <= {sh_q[6:0], sda_s};
        cnt_q <= cnt_q + 4'h1;
      end
      if (st_q == ST_ACKR) begin
        nack_q <= sda_s;
      end
    end else if (scl_fall) begin
      case (st_q)
        ST_ADDR: begin
          if (cnt_q == 4'h8) begin
            cnt_q <= '0;
            if (sh_q[7:1] == DEV_ADDR) begin
              st_q     <= ST_ACKA;
              sda_oe_q <= 1'b1;
              rw_q     <= sh_q[0];
            end else begin
              st_q <= ST_IDLE;
            end
          end
        end
        ST_PTR: begin
          if (cnt_q == 4'h8) begin
            cnt_q    <= '0;
            ptr_q    <= sh_q;
            sda_oe_q <= 1'b1;
            st_q     <= ST_ACKP;
          end
        end
        ST_WDAT: begin
          if (cnt_q == 4'h8) begin
            cnt_q     <= '0;
            wr_en_q   <= 1'b1;
            wr_addr_q <= ptr_q;
            wr_data_q <= sh_q;
            ptr_q     <= ptr_q + 8'h1;
            sda_oe_q  <= 1'b1;
            st_q      <= ST_ACKW;
          end
        end
        ST_ACKP, ST_ACKW: begin
          sda_oe_q <= 1'b0;
          st_q     <= ST_WDAT;
        end
        ST_RDAT: begin
          if (cnt_q == 4'h7) begin
            sda_oe_q <= 1'b0;
            st_q     <= ST_ACKR;
          end else begin
            out_q    <= {out_q[6:0], 1'b0};
            sda_oe_q <= ~out_q[6];
            cnt_q    <= cnt_q + 4'h1;
          end
        end
        ST_ACKA, ST_ACKR: begin
          if (st_q == ST_ACKA && !rw_q) begin
            sda_oe_q <= 1'b0;
            st_q     <= ST_PTR;
          end else if (st_q == ST_ACKR && nack_q) begin
            st_q <= ST_IDLE;
          end else begin
            out_q      <= rd_byte;
            sda_oe_q   <= ~rd_byte[7];
            rd_fault_q <= (ptr_q == `CFR_REG_FAULT);
            ptr_q      <= ptr_q + 8'h1;
            cnt_q      <= '0;
            st_q       <= ST_RDAT;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Open drain: only ever pulls low
  always_ff @(posedge clk) begin
    sda_out_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault flags
  assign fault_set = {short_det, ipk_s, warn_s, shut_s};
  assign fault_clr = (wr_en_q && wr_addr_q == `CFR_REG_FAULT) ? (wr_data_q[3:0] & armed_q) : 4'h0;

  // Set wins over a clear landing in the same cycle
  always_ff @(posedge clk) begin
    if (rst || !vbus_s) begin
      fault_q <= 4'h0;
    end else begin
      fault_q <= (fault_q & ~fault_clr) | fault_set;
    end
  end

  // Only bits that were high when read may be cleared by the next write
  always_ff @(posedge clk) begin
    if (rst || !vbus_s) begin
      armed_q <= 4'h0;
    end else if (rd_fault_q) begin
      armed_q <= armed_q | fault_q;
    end else if (wr_en_q && wr_addr_q == `CFR_REG_FAULT) begin
      armed_q <= 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      short_q <= '{timeout: `CFR_SHORT_TMO_RST, volt: `CFR_SHORT_VLT_RST};
    end else if (wr_en_q && wr_addr_q == `CFR_REG_SHORT) begin
      short_q <= '{timeout: wr_data_q[7:5], volt: wr_data_q[2:0]};
    end
  end

  // Beta stays writable; a host overwrite loses the factory trim
  always_ff @(posedge clk) begin
    if (rst) begin
      therm_q <= {`CFR_THERM_HI_RST, RNTC_FACTORY, BETA_FACTORY};
    end else if (wr_en_q && wr_addr_q == `CFR_REG_THERM) begin
      therm_q <= wr_data_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      thr_mv_q <= '0;
      beta_q   <= '0;
    end else begin
      thr_mv_q <= `CFR_VTHR_BASE_MV + `CFR_VTHR_STEP_MV * 12'(short_q.volt);
      beta_q   <= beta_of(therm_q.beta);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Charge limits from thermistor zones and shutdown
  assign cool   = temp_s.lt_10c & ~temp_s.lt_0c;
  assign stop_d = (therm_q.low_sel ? temp_s.lt_10c : temp_s.lt_0c)
                | (therm_q.high_sel ? temp_s.gt_60c : temp_s.gt_45c)
                | fault_q[`CFR_FLT_SHUT];

  always_ff @(posedge clk) begin
    if (rst) begin
      stop_q  <= 1'b1;
      scale_q <= CS_OFF;
    end else begin
      stop_q  <= stop_d;
      scale_q <= stop_d ? CS_OFF : !cool ? CS_FULL
               : therm_q.cool_sel ? CS_TENTH : CS_HALF;
    end
  end

  assign sda_out         = sda_out_q;
  assign sda_oe          = sda_oe_q;
  assign short_cfg       = short_q;
  assign short_thr_mv    = thr_mv_q;
  assign therm_cfg       = therm_q;
  assign beta_value      = beta_q;
  assign device_shutdown = fault_q[`CFR_FLT_SHUT];
  assign charge_stop     = stop_q;
  assign cur_scale       = scale_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  short_flag_a: assert property (short_det && vbus_s |=> fault_q[`CFR_FLT_SHORT])
    else $error("battery short flag not set");
  peak_flag_a: assert property (ipk_s && vbus_s |=> fault_q[`CFR_FLT_PEAK])
    else $error("inductor peak flag not set");
  warn_flag_a: assert property (warn_s && vbus_s |=> fault_q[`CFR_FLT_WARN])
    else $error("overtemperature warning flag not set");
  shutdown_a: assert property (shut_s && vbus_s |=> device_shutdown ##1 charge_stop)
    else $error("overtemperature did not shut down");
  flag_sticky_a: assert property (vbus_s && !(wr_en_q && wr_addr_q == `CFR_REG_FAULT)
    |=> (fault_q & $past(fault_q)) == $past(fault_q))
    else $error("fault flag dropped without clear");
  power_clear_a: assert property (!vbus_s |=> fault_q == 4'h0)
    else $error("flags survived supply loss");
  short_thr_a: assert property (short_q.volt == 3'h7 |=> short_thr_mv == 12'd2700)
    else $error("short threshold wrong");
  cool_scale_a: assert property (cool && !stop_d
    |=> cur_scale == ($past(therm_q.cool_sel) ? CS_TENTH : CS_HALF))
    else $error("cool range current wrong");
  cold_stop_a: assert property (temp_s.lt_0c |=> charge_stop)
    else $error("charging not stopped when cold");
  hot_stop_a: assert property (temp_s.gt_45c && !therm_q.high_sel |=> charge_stop)
    else $error("charging not stopped above 45 C");
  beta_map_a: assert property (therm_q.beta == 4'hf |=> beta_value == 13'd5200)
    else $error("beta mapping wrong");

endmodule : cfr_top

`default_nettype wire
